/* File: rtl/lca_pkg.sv */
// Purpose: shared constants and types for the loadable cascadable accumulator
// Assumes: 32-bit apb data, one aligned word per register
// Notes: widths of the accumulator itself are module parameters
package lca_pkg;

    // ==========================================================
    // accumulator widths
    localparam int LCA_WIDE_WIDTH = 16;
    localparam int LCA_NARROW_WIDTH = 4;

    // ==========================================================
    // register map
    localparam int LCA_ADDR_W = 12;
    localparam logic [11:0] LCA_OFS_VALUE = 12'h000;
    localparam logic [11:0] LCA_OFS_FLAGS = 12'h004;
    localparam logic [11:0] LCA_OFS_CTRL = 12'h008;
    localparam logic [11:0] LCA_OFS_STICKY = 12'h00c;

    // ==========================================================
    // field positions
    localparam int LCA_FLAGS_CARRY_BIT = 0;
    localparam int LCA_FLAGS_SOVF_BIT = 1;
    localparam int LCA_FLAGS_UOVF_BIT = 2;
    localparam int LCA_CTRL_TRACK_BIT = 0;
    localparam int LCA_STICKY_UOVF_BIT = 0;
    localparam int LCA_STICKY_SOVF_BIT = 1;

    // ==========================================================
    // reset values
    localparam logic LCA_CTRL_TRACK_RST = 1'b0;
    localparam logic [1:0] LCA_STICKY_RST = 2'h0;
    localparam logic [31:0] LCA_PRDATA_RST = 32'h0000_0000;

    // ==========================================================
    // types
    typedef struct packed {
        logic carry_out;
        logic signed_overflow;
    } lca_flags_t;

endpackage

/* File: rtl/lca_addsub.sv */
// Purpose: combinational add/subtract stage of the accumulator
// Assumes: sum_dir high adds, low subtracts
// Notes: subtract is done as acc + ~operand + ~carry_in
`timescale 1ns/1ps
module lca_addsub
    import lca_pkg::*;
#(
    parameter int WIDTH = LCA_WIDE_WIDTH
) (
    input wire logic [WIDTH-1:0] acc_in,
    input wire logic [WIDTH-1:0] operand_in,
    input wire logic carry_in_in,
    input wire logic sum_dir_in,
    output logic [WIDTH-1:0] result_out,
    output lca_flags_t flags_out
);

    // ==========================================================
    // operand conditioning and sum
    logic [WIDTH-1:0] eff_operand;
    logic eff_carry;
    logic [WIDTH:0] total;

    always_comb begin
        eff_operand = sum_dir_in ? operand_in : ~operand_in;
        eff_carry = sum_dir_in ? carry_in_in : ~carry_in_in;
        total = {1'b0, acc_in} + {1'b0, eff_operand} + {{WIDTH{1'b0}}, eff_carry};
        result_out = total[WIDTH-1:0];
        // carry in add, active-low borrow in subtract
        flags_out.carry_out = total[WIDTH];
        flags_out.signed_overflow = (acc_in[WIDTH-1] == eff_operand[WIDTH-1])
            && (total[WIDTH-1] != acc_in[WIDTH-1]);
    end

endmodule

/* File: rtl/lca_top.sv */
// Purpose: loadable cascadable accumulator with apb status window
// Assumes: datapath inputs come from logic on CLK_IN; global reset pin is asynchronous
// Notes: carry and signed overflow outputs are combinational for cascading
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module lca_top
    import lca_pkg::*;
#(
    parameter int WIDTH = LCA_WIDE_WIDTH,
    parameter bit GSR_INVERT = 1'b0
) (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic CE_IN,
    input wire logic WIPE_IN,
    input wire logic PRESET_IN,
    input wire logic SUM_DIR_IN,
    input wire logic CARRY_IN_IN,
    input wire logic [WIDTH-1:0] OPERAND_IN,
    input wire logic [WIDTH-1:0] LOAD_VALUE_IN,
    input wire logic GLOBAL_SET_RESET_IN,
    output logic [WIDTH-1:0] ACC_OUT,
    output logic CARRY_OUT_OUT,
    output logic SIGNED_OVERFLOW_OUT,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [LCA_ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT
);

    // ==========================================================
    // reset combination
    logic gsr_active;
    logic rst_n;

    assign gsr_active = GSR_INVERT ? ~GLOBAL_SET_RESET_IN : GLOBAL_SET_RESET_IN;
    assign rst_n = RST_B_IN & ~gsr_active;

    // ==========================================================
    // datapath
    logic [WIDTH-1:0] acc;
    logic [WIDTH-1:0] next_acc;
    logic [WIDTH-1:0] result;
    lca_flags_t flags;

    lca_addsub #(
        .WIDTH(WIDTH)
    ) u_addsub (
        .acc_in(acc),
        .operand_in(OPERAND_IN),
        .carry_in_in(CARRY_IN_IN),
        .sum_dir_in(SUM_DIR_IN),
        .result_out(result),
        .flags_out(flags)
    );

    always_comb begin
        if (WIPE_IN) begin
            next_acc = '0;
        end else if (PRESET_IN) begin
            next_acc = LOAD_VALUE_IN;
        end else if (CE_IN) begin
            next_acc = result;
        end else begin
            next_acc = acc;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

    assign ACC_OUT = acc;
    assign CARRY_OUT_OUT = flags.carry_out;
    assign SIGNED_OVERFLOW_OUT = flags.signed_overflow;

    // ==========================================================
    // sticky overflow tracking
    logic track;
    logic next_track;
    logic [1:0] sticky;
    logic [1:0] next_sticky;
    logic step;
    logic [1:0] sticky_set;
    logic [1:0] sticky_clr;
    logic uovf;
    logic apb_setup;
    logic apb_wr;

    assign apb_setup = PSEL_IN & ~PENABLE_IN;
    assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
    assign uovf = flags.carry_out ^ SUM_DIR_IN;
    assign step = CE_IN & ~WIPE_IN & ~PRESET_IN;

    always_comb begin
        next_track = track;
        sticky_set = 2'h0;
        sticky_clr = 2'h0;
        if (apb_wr && PADDR_IN == LCA_OFS_CTRL) begin
            next_track = PWDATA_IN[LCA_CTRL_TRACK_BIT];
        end
        if (apb_wr && PADDR_IN == LCA_OFS_STICKY) begin
            sticky_clr[LCA_STICKY_UOVF_BIT] = PWDATA_IN[LCA_STICKY_UOVF_BIT];
            sticky_clr[LCA_STICKY_SOVF_BIT] = PWDATA_IN[LCA_STICKY_SOVF_BIT];
        end
        if (track && step) begin
            sticky_set[LCA_STICKY_UOVF_BIT] = uovf;
            sticky_set[LCA_STICKY_SOVF_BIT] = flags.signed_overflow;
        end
        // set wins over clear
        next_sticky = (sticky & ~sticky_clr) | sticky_set;
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            track <= LCA_CTRL_TRACK_RST;
            sticky <= LCA_STICKY_RST;
        end else begin
            track <= next_track;
            sticky <= next_sticky;
        end
    end

    // ==========================================================
    // apb read path and error
    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic pslverr;
    logic next_pslverr;
    logic [31:0] rd_word;
    logic mapped;

    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        case (PADDR_IN)
            LCA_OFS_VALUE: begin
                rd_word[WIDTH-1:0] = acc;
            end
            LCA_OFS_FLAGS: begin
                rd_word[LCA_FLAGS_CARRY_BIT] = flags.carry_out;
                rd_word[LCA_FLAGS_SOVF_BIT] = flags.signed_overflow;
                rd_word[LCA_FLAGS_UOVF_BIT] = uovf;
            end
            LCA_OFS_CTRL: begin
                rd_word[LCA_CTRL_TRACK_BIT] = track;
            end
            LCA_OFS_STICKY: begin
                rd_word[1:0] = sticky;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (apb_setup) begin
            next_prdata = PWRITE_IN ? 32'h0000_0000 : rd_word;
            next_pslverr = ~mapped;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= LCA_PRDATA_RST;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    assign PRDATA_OUT = prdata;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = pslverr & PSEL_IN & PENABLE_IN;

    // ==========================================================
    // reference arithmetic for checks
    logic [WIDTH:0] chk_add;
    logic [WIDTH:0] chk_sub;
    logic [WIDTH+1:0] chk_sadd;
    logic [WIDTH+1:0] chk_ssub;
    logic chk_sovf;

    // guard bits of a sign-extended sum agree
    function automatic logic top_agree(input logic [2:0] top);
        return (top == 3'b000) || (top == 3'b111);
    endfunction

    always_comb begin
        chk_add = {1'b0, acc} + {1'b0, OPERAND_IN} + {{WIDTH{1'b0}}, CARRY_IN_IN};
        chk_sub = {1'b0, acc} - {1'b0, OPERAND_IN} - {{WIDTH{1'b0}}, CARRY_IN_IN};
        chk_sadd = {{2{acc[WIDTH-1]}}, acc} + {{2{OPERAND_IN[WIDTH-1]}}, OPERAND_IN}
            + {{(WIDTH+1){1'b0}}, CARRY_IN_IN};
        chk_ssub = {{2{acc[WIDTH-1]}}, acc} - {{2{OPERAND_IN[WIDTH-1]}}, OPERAND_IN}
            - {{(WIDTH+1){1'b0}}, CARRY_IN_IN};
        if (SUM_DIR_IN) begin
            chk_sovf = !top_agree(chk_sadd[WIDTH+1:WIDTH-1]);
        end else begin
            chk_sovf = !top_agree(chk_ssub[WIDTH+1:WIDTH-1]);
        end
    end

    // ==========================================================
    // assertions
    AST_WIPE_CLEARS: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        WIPE_IN |=> (ACC_OUT == '0))
        else $error("wipe did not clear accumulator");

    AST_PRESET_LOADS: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (!WIPE_IN && PRESET_IN) |=> (ACC_OUT == $past(LOAD_VALUE_IN)))
        else $error("preset did not load value");

    AST_ADD_STEP: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (!WIPE_IN && !PRESET_IN && CE_IN && SUM_DIR_IN)
        |=> (ACC_OUT == $past(chk_add[WIDTH-1:0])))
        else $error("add step stored wrong value");

    AST_SUB_STEP: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (!WIPE_IN && !PRESET_IN && CE_IN && !SUM_DIR_IN)
        |=> (ACC_OUT == $past(chk_sub[WIDTH-1:0])))
        else $error("subtract step stored wrong value");

    AST_HOLD_NO_CE: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (!WIPE_IN && !PRESET_IN && !CE_IN) |=> $stable(ACC_OUT))
        else $error("accumulator changed with enable low");

    AST_CARRY_ADD: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        SUM_DIR_IN |-> (CARRY_OUT_OUT == chk_add[WIDTH]))
        else $error("carry out wrong in add");

    AST_BORROW_SUB: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !SUM_DIR_IN |-> (CARRY_OUT_OUT == !chk_sub[WIDTH]))
        else $error("borrow out wrong in subtract");

    AST_SIGNED_OVF: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        SIGNED_OVERFLOW_OUT == chk_sovf)
        else $error("signed overflow wrong");

    AST_STICKY_SET_WINS: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (track && step && uovf) |=> sticky[LCA_STICKY_UOVF_BIT])
        else $error("sticky unsigned overflow lost");

    AST_RESET_CLEARS: assert property (@(posedge CLK_IN)
        !rst_n |=> ((ACC_OUT == '0) && (PRDATA_OUT == LCA_PRDATA_RST) && !PSLVERR_OUT))
        else $error("reset did not clear state");

    AST_TRACK_WRITE: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (apb_wr && (PADDR_IN == LCA_OFS_CTRL))
        |=> (track == $past(PWDATA_IN[LCA_CTRL_TRACK_BIT])))
        else $error("control write not stored");

    AST_STICKY_SOVF_CLEARS: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (apb_wr && (PADDR_IN == LCA_OFS_STICKY) && PWDATA_IN[LCA_STICKY_SOVF_BIT]
        && !(track && step && flags.signed_overflow)) |=> !sticky[LCA_STICKY_SOVF_BIT])
        else $error("sticky signed overflow not cleared");

    AST_STICKY_UOVF_CLEARS: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (apb_wr && (PADDR_IN == LCA_OFS_STICKY) && PWDATA_IN[LCA_STICKY_UOVF_BIT]
        && !(track && step && uovf)) |=> !sticky[LCA_STICKY_UOVF_BIT])
        else $error("sticky unsigned overflow not cleared");

    AST_PRDATA_HOLDS: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !apb_setup |=> $stable(PRDATA_OUT))
        else $error("read data changed outside setup");

    AST_SLVERR_UNMAPPED: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (apb_setup && !mapped) |=> (!PENABLE_IN || PSLVERR_OUT))
        else $error("unmapped access gave no error");

    AST_READ_VALUE: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (apb_setup && !PWRITE_IN && (PADDR_IN == LCA_OFS_VALUE))
        |=> (PRDATA_OUT[WIDTH-1:0] == $past(ACC_OUT)))
        else $error("value read returned wrong word");

    AST_FLAGS_READ: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (apb_setup && !PWRITE_IN && (PADDR_IN == LCA_OFS_FLAGS))
        |=> (PRDATA_OUT[LCA_FLAGS_SOVF_BIT] == $past(SIGNED_OVERFLOW_OUT)))
        else $error("flags read returned wrong overflow");

endmodule

/* File: sim/lca_user_model.sv */
// Purpose: user logic model driving the accumulator datapath
// Assumes: random seed is set once by the bench
// Notes: paused means no wipe, preset or enable; operands held
`timescale 1ns/1ps
module lca_user_model (
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic carry_low_in,
    output logic ce_out,
    output logic wipe_out,
    output logic preset_out,
    output logic dir_out,
    output logic ci_out,
    output logic [15:0] op_out,
    output logic [15:0] ld_out
);
    // ==========================================================
    // stimulus
    initial begin
        {ce_out, wipe_out, preset_out, dir_out, ci_out} = 5'h00;
        op_out = 16'h0000;
        ld_out = 16'h0000;
    end
    always @(posedge clk_in) begin
        ce_out <= en_in && ($urandom % 4 != 0);
        wipe_out <= en_in && ($urandom % 8 == 0);
        preset_out <= en_in && ($urandom % 4 == 0);
        if (en_in) begin
            dir_out <= 1'($urandom);
            ci_out <= ($urandom % 2) ? carry_low_in : 1'($urandom);
            op_out <= 16'($urandom);
            ld_out <= 16'($urandom);
        end
    end
    // flags are judged per number format by the bench
endmodule

/* File: sim/tb_loadable_cascadable_accumulator.sv */
// Purpose: self-checking bench for narrow and wide accumulators
// Assumes: all three instances share datapath and apb inputs; apb read on the narrow one
// Notes: integer model updated at each falling edge
`timescale 1ns/1ps
module tb_loadable_cascadable_accumulator;
    import lca_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic global_set_reset = 1'b0;
    logic en = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic ce, wipe, preset, dir, ci, co_n, ov_n, co_w, ov_w, pready, pslverr, err;
    logic [15:0] op, ld, acc_w;
    logic [3:0] acc_n, acc_i;
    logic [31:0] prdata, rd;
    int error_cnt = 0;
    int n_compared = 0;
    int m_acc[2] = '{0, 0};
    bit stk_u, stk_s, track, m_co, m_ov, run;

    // ==========================================================
    // clock and instances
    always #10 clk = ~clk;
    lca_user_model lca_user_model_inst (.clk_in(clk), .en_in(en), .carry_low_in(co_n),
        .ce_out(ce), .wipe_out(wipe), .preset_out(preset), .dir_out(dir), .ci_out(ci),
        .op_out(op), .ld_out(ld));
    lca_top #(.WIDTH(4)) lca_top_inst (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
        .WIPE_IN(wipe), .PRESET_IN(preset), .SUM_DIR_IN(dir), .CARRY_IN_IN(ci),
        .OPERAND_IN(op[3:0]), .LOAD_VALUE_IN(ld[3:0]), .GLOBAL_SET_RESET_IN(global_set_reset),
        .ACC_OUT(acc_n), .CARRY_OUT_OUT(co_n), .SIGNED_OVERFLOW_OUT(ov_n),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
    lca_top #(.WIDTH(16)) lca_top_inst_w (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
        .WIPE_IN(wipe), .PRESET_IN(preset), .SUM_DIR_IN(dir), .CARRY_IN_IN(ci),
        .OPERAND_IN(op), .LOAD_VALUE_IN(ld), .GLOBAL_SET_RESET_IN(global_set_reset),
        .ACC_OUT(acc_w), .CARRY_OUT_OUT(co_w), .SIGNED_OVERFLOW_OUT(ov_w),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(), .PREADY_OUT(), .PSLVERR_OUT());
    lca_top #(.WIDTH(4), .GSR_INVERT(1'b1)) lca_top_inst_i (.CLK_IN(clk), .RST_B_IN(rst_b),
        .CE_IN(ce), .WIPE_IN(wipe), .PRESET_IN(preset), .SUM_DIR_IN(dir), .CARRY_IN_IN(ci),
        .OPERAND_IN(op[3:0]), .LOAD_VALUE_IN(ld[3:0]), .GLOBAL_SET_RESET_IN(~global_set_reset),
        .ACC_OUT(acc_i), .CARRY_OUT_OUT(), .SIGNED_OVERFLOW_OUT(),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(), .PREADY_OUT(), .PSLVERR_OUT());

    // ==========================================================
    // model and checks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic void step(input int w, a, b, input bit c, add,
        output int nx, output bit co, output bit ov);
        int m, r, sa, sb;
        m = 1 << w;
        sa = (a >= m / 2) ? a - m : a;
        sb = (b >= m / 2) ? b - m : b;
        r = add ? a + b + c : a - b - c;
        co = add ? (r >= m) : (r >= 0);
        nx = (r + m) % m;
        r = add ? sa + sb + c : sa - sb - c;
        ov = (r >= m / 2) || (r < -(m / 2));
    endfunction
    task automatic chk_inst(input int i, input logic [15:0] a, input logic co, input logic ov);
        int w, nx;
        bit c, o;
        w = i ? 16 : 4;
        chk("acc", {16'h0, a}, 32'(m_acc[i]));
        step(w, m_acc[i], int'(op) % (1 << w), ci, dir, nx, c, o);
        chk("carry", {31'h0, co}, {31'h0, c});
        chk("sovf", {31'h0, ov}, {31'h0, o});
        if (!rst_b || global_set_reset || wipe)
            nx = 0;
        else if (preset)
            nx = int'(ld) % (1 << w);
        else if (!ce)
            nx = m_acc[i];
        else if (i == 0 && track) begin
            stk_u |= c ^ dir;
            stk_s |= o;
        end
        if (i == 0) begin
            m_co = c;
            m_ov = o;
        end
        m_acc[i] = nx;
    endtask
    always @(negedge clk) begin
        if (run) begin
            chk("acc_inv", {28'h0, acc_i}, 32'(m_acc[0]));
            chk_inst(0, {12'h0, acc_n}, co_n, ov_n);
            chk_inst(1, acc_w, co_w, ov_w);
        end
    end

    // ==========================================================
    // bus and control tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pause();
        en <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // sequence
    initial begin
        void'($urandom(32'h4a69bbd4));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        run <= 1'b1;
        en <= 1'b1;
        repeat (300) @(posedge clk);
        pause();
        apb(1'b0, LCA_OFS_VALUE, 32'h0);
        chk("value", rd, 32'(m_acc[0]));
        apb(1'b0, LCA_OFS_FLAGS, 32'h0);
        chk("flags", rd, {29'h0, m_co ^ dir, m_ov, m_co});
        apb(1'b1, LCA_OFS_VALUE, 32'h5);
        apb(1'b0, LCA_OFS_VALUE, 32'h0);
        chk("ro", rd, 32'(m_acc[0]));
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        apb(1'b1, LCA_OFS_CTRL, 32'h1);
        track = 1'b1;
        en <= 1'b1;
        repeat (300) @(posedge clk);
        pause();
        apb(1'b0, LCA_OFS_STICKY, 32'h0);
        chk("sticky", rd, {30'h0, stk_s, stk_u});
        apb(1'b1, LCA_OFS_STICKY, 32'h3);
        stk_u = 1'b0;
        stk_s = 1'b0;
        apb(1'b0, LCA_OFS_STICKY, 32'h0);
        chk("clear", rd, 32'h0);
        en <= 1'b1;
        repeat (50) @(posedge clk);
        global_set_reset <= 1'b1;
        m_acc = '{0, 0};
        track = 1'b0;
        stk_u = 1'b0;
        stk_s = 1'b0;
        @(negedge clk);
        chk("gsr", {16'h0, acc_w}, 32'h0);
        chk("gsr_inv", {28'h0, acc_i}, 32'h0);
        @(posedge clk);
        global_set_reset <= 1'b0;
        repeat (100) @(posedge clk);
        pause();
        apb(1'b0, LCA_OFS_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(1'b0, LCA_OFS_STICKY, 32'h0);
        chk("sticky_rst", rd, {30'h0, stk_s, stk_u});
        finish_test();
    end
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
endmodule
